// ===== core/d2pi_core.sv
// Purpose: device-side pin logic of a double-data-rate DRAM: command decode,
//   mode registers, termination, masked writes, strobed read bursts
// Assumes: pins are asynchronous to sys_clk and much slower than it
// Notes: all pins pass a three-stage synchroniser; a change counts once
//   stages two and three agree
`timescale 1ns/1ps
`default_nettype none

// three-stage pin synchroniser; only stages two and three leave
module d2pi_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] s2,
  output logic [W-1:0] s3
);
  logic [W-1:0] s1;

  // shift chain
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end
endmodule // d2pi_sync

module d2pi_core (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ck,
  input wire logic ck_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [d2pi_pkg::BA_W-1:0] ba,
  input wire logic [d2pi_pkg::ADDR_W-1:0] addr,
  input wire logic odt,
  input wire logic dm_l,
  input wire logic dm_u,
  input wire logic org_x8,
  input wire logic [d2pi_pkg::DQ_W-1:0] dq_in,
  output logic [d2pi_pkg::DQ_W-1:0] dq_out,
  output logic [1:0] dq_oe,
  input wire logic [1:0] dqs_in,
  output logic [1:0] dqs_out,
  output logic [1:0] dqs_n_out,
  output logic [1:0] dqs_oe,
  output logic [1:0] dqs_n_oe,
  output logic odt_term,
  output logic [d2pi_pkg::N_BANKS-1:0] bank_open,
  output logic [d2pi_pkg::ADDR_W-1:0] mode_reg,
  output logic [d2pi_pkg::ADDR_W-1:0] ext_mode_reg1
);
  import d2pi_pkg::*;

  logic [SYNC_W-1:0] pin_s2;
  logic [SYNC_W-1:0] pin_s3;
  logic [SYNC_W-1:0] pin_f;
  logic [SYNC_W-1:0] next_pin_f;
  logic ck_rise, ck_edge, dqsl_edge, dqsu_edge;
  logic [3:0] cmd;
  logic [BA_W-1:0] ba_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DQ_W-1:0] dq_s;
  logic cke_s, odt_s, dml_s, dmu_s, x8_s;
  d2pi_state_t state, next_state;
  logic [BA_W-1:0] bur_bank, next_bur_bank;
  logic [4:0] bur_col, next_bur_col;
  logic bur_ap, next_bur_ap;
  logic [BEAT_W-1:0] cnt_l, next_cnt_l, cnt_u, next_cnt_u;
  logic [BEAT_W-1:0] bl_beats;
  logic dm_en, rdqs_en, next_odt_term;
  logic [N_BANKS-1:0] next_bank_open;
  logic [ADDR_W-1:0] next_mode_reg, next_ext_mode_reg1;
  logic [DQ_W-1:0] next_dq_out;
  logic [1:0] next_dq_oe, next_dqs_out, next_dqs_n_out, next_dqs_oe, next_dqs_n_oe;
  logic we_l, we_u;
  logic [IDX_W-1:0] idx_l, idx_u;
  logic [BYTE_W-1:0] mem_l [MEM_DEPTH];
  logic [BYTE_W-1:0] mem_u [MEM_DEPTH];

  // every pin crosses into sys_clk through three stages
  d2pi_sync #(.W(SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .d({ck & ~ck_n, dqs_in, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm_l,
        dm_u, org_x8, dq_in}),
    .s2(pin_s2),
    .s3(pin_s3)
  );

  // field slices of the agreed levels
  assign dq_s = next_pin_f[15:0];
  assign x8_s = next_pin_f[16];
  assign dmu_s = next_pin_f[17];
  assign dml_s = next_pin_f[18];
  assign odt_s = next_pin_f[19];
  assign addr_s = next_pin_f[33:20];
  assign ba_s = next_pin_f[36:34];
  assign cmd = next_pin_f[40:37];
  assign cke_s = next_pin_f[41];

  // every bit moves only when stages two and three agree, so a pin caught
  // mid-change by the first stage never shows a one-cycle glitch
  always_comb begin
    next_pin_f = (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_f);
  end

  // edge flags: ck high and ck_n low marks the rising crossing
  assign ck_rise = next_pin_f[44] & ~pin_f[44];
  assign ck_edge = next_pin_f[44] ^ pin_f[44];
  assign dqsl_edge = next_pin_f[42] ^ pin_f[42];
  assign dqsu_edge = next_pin_f[43] ^ pin_f[43];

  // option decode from the mode registers
  assign bl_beats = (mode_reg[MR_BL_LSB +: 3] == BL_CODE_8) ? BL_BEATS_8 : BL_BEATS_4;
  assign rdqs_en = x8_s & ext_mode_reg1[EMR1_RDQS_BIT];
  assign dm_en = ~rdqs_en;

  // burst word index, sequential or interleaved wrap inside the burst
  function automatic logic [IDX_W-1:0] beat_idx(input logic [BA_W-1:0] bk,
      input logic [4:0] col, input logic [BEAT_W-1:0] beat, input logic bl8,
      input logic ilv);
    logic [2:0] ofs;
    ofs = ilv ? (col[2:0] ^ beat[2:0]) : (col[2:0] + beat[2:0]);
    if (!bl8) begin
      ofs[2] = col[2];
    end
    beat_idx = {bk, col[4:3], ofs};
  endfunction

  assign idx_l = beat_idx(bur_bank, bur_col, cnt_l, bl_beats == BL_BEATS_8,
      mode_reg[MR_BT_BIT]);
  assign idx_u = beat_idx(bur_bank, bur_col, cnt_u, bl_beats == BL_BEATS_8,
      mode_reg[MR_BT_BIT]);

  // command decode, burst sequencing and pin drive
  always_comb begin
    next_state = state;
    next_bur_bank = bur_bank;
    next_bur_col = bur_col;
    next_bur_ap = bur_ap;
    next_cnt_l = cnt_l;
    next_cnt_u = cnt_u;
    next_bank_open = bank_open;
    next_mode_reg = mode_reg;
    next_ext_mode_reg1 = ext_mode_reg1;
    next_odt_term = odt_term;
    next_dq_out = dq_out;
    next_dq_oe = dq_oe;
    next_dqs_out = dqs_out;
    next_dqs_n_out = dqs_n_out;
    next_dqs_oe = dqs_oe;
    next_dqs_n_oe = dqs_n_oe;
    we_l = 1'b0;
    we_u = 1'b0;
    // termination follows the registered input unless disabled
    if (ck_rise) begin
      next_odt_term = odt_s & (ext_mode_reg1[EMR1_RTT0_BIT] |
          ext_mode_reg1[EMR1_RTT1_BIT]);
    end
    // a command is taken at the rising crossing; chip select high masks it
    if (ck_rise && cke_s && !cmd[3]) begin
      unique case (cmd)
        CMD_MRS: begin
          if (ba_s == SEL_MR) begin
            next_mode_reg = addr_s;
          end else if (ba_s == SEL_EMR1) begin
            next_ext_mode_reg1 = addr_s;
          end
        end
        CMD_ACT: begin
          next_bank_open[ba_s] = 1'b1;
        end
        CMD_PRE: begin
          if (addr_s[AP_BIT]) begin
            next_bank_open = '0;
          end else begin
            next_bank_open[ba_s] = 1'b0;
          end
        end
        CMD_WR, CMD_RD: begin
          if (state == ST_IDLE && bank_open[ba_s]) begin
            next_state = (cmd == CMD_WR) ? ST_WR : ST_RD;
            next_bur_bank = ba_s;
            next_bur_col = addr_s[4:0];
            next_bur_ap = addr_s[AP_BIT];
            next_cnt_l = '0;
            next_cnt_u = '0;
          end
        end
        default: begin
        end
      endcase
    end
    unique case (state)
      ST_IDLE: begin
      end
      ST_WR: begin
        // lower strobe times bits 0-7 (all data on eight-bit parts)
        if (dqsl_edge && cnt_l != bl_beats) begin
          we_l = ~(dm_en & dml_s);
          next_cnt_l = cnt_l + 4'h1;
        end
        // upper strobe times bits 8-15 on sixteen-bit parts
        if (!x8_s && dqsu_edge && cnt_u != bl_beats) begin
          we_u = ~dmu_s;
          next_cnt_u = cnt_u + 4'h1;
        end
        if (next_cnt_l == bl_beats && (x8_s || next_cnt_u == bl_beats)) begin
          next_state = ST_IDLE;
          if (bur_ap) begin
            next_bank_open[bur_bank] = 1'b0;
          end
        end
      end
      ST_RD: begin
        // one beat per clock crossing, strobe toggles with the data
        if (ck_edge) begin
          if (cnt_l != bl_beats) begin
            next_dq_out = {mem_u[idx_l], mem_l[idx_l]};
            next_dq_oe = x8_s ? 2'h1 : 2'h3;
            next_dqs_out = {2{~cnt_l[0]}};
            next_dqs_n_out = {2{cnt_l[0]}};
            next_dqs_oe = (x8_s && !rdqs_en) ? 2'h1 : 2'h3;
            next_dqs_n_oe = ext_mode_reg1[EMR1_DQSN_DIS_BIT] ? 2'h0 : next_dqs_oe;
            next_cnt_l = cnt_l + 4'h1;
          end else begin
            next_dq_oe = 2'h0;
            next_dqs_oe = 2'h0;
            next_dqs_n_oe = 2'h0;
            next_dqs_out = 2'h0;
            next_dqs_n_out = 2'h0;
            next_state = ST_IDLE;
            if (bur_ap) begin
              next_bank_open[bur_bank] = 1'b0;
            end
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // control registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_f <= '0;
      state <= ST_IDLE;
      bur_bank <= '0;
      bur_col <= '0;
      bur_ap <= 1'b0;
      cnt_l <= '0;
      cnt_u <= '0;
      bank_open <= '0;
      mode_reg <= MR_RST;
      ext_mode_reg1 <= EMR1_RST;
      odt_term <= 1'b0;
      dq_out <= '0;
      dq_oe <= 2'h0;
      dqs_out <= 2'h0;
      dqs_n_out <= 2'h0;
      dqs_oe <= 2'h0;
      dqs_n_oe <= 2'h0;
    end else begin
      pin_f <= next_pin_f;
      state <= next_state;
      bur_bank <= next_bur_bank;
      bur_col <= next_bur_col;
      bur_ap <= next_bur_ap;
      cnt_l <= next_cnt_l;
      cnt_u <= next_cnt_u;
      bank_open <= next_bank_open;
      mode_reg <= next_mode_reg;
      ext_mode_reg1 <= next_ext_mode_reg1;
      odt_term <= next_odt_term;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
      dqs_out <= next_dqs_out;
      dqs_n_out <= next_dqs_n_out;
      dqs_oe <= next_dqs_oe;
      dqs_n_oe <= next_dqs_n_oe;
    end
  end

  // byte-lane storage, written only for unmasked beats, or for every lower-lane beat on eight-bit parts with the redundant strobe on
  always_ff @(posedge sys_clk) begin
    if (we_l) begin
      mem_l[idx_l] <= dq_s[7:0];
    end
    if (we_u) begin
      mem_u[idx_u] <= dq_s[15:8];
    end
  end
endmodule // d2pi_core

`default_nettype wire

// ===== core/d2pi_pkg.sv
// Purpose: constants for the double-data-rate DRAM pin interface model
// Assumes: command code is {cs_n, ras_n, cas_n, we_n}
// Notes: mode register reset values select burst of four, termination off
package d2pi_pkg;
  // bus widths and memory shape
  localparam int DQ_W = 16;
  localparam int BYTE_W = 8;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int N_BANKS = 8;
  localparam int MEM_DEPTH = 256;
  localparam int IDX_W = 8;
  localparam int BEAT_W = 4;
  localparam int SYNC_W = 45;

  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // address field positions
  localparam int AP_BIT = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int EMR1_RTT0_BIT = 2;
  localparam int EMR1_RTT1_BIT = 6;
  localparam int EMR1_DQSN_DIS_BIT = 10;
  localparam int EMR1_RDQS_BIT = 11;

  // field codes
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [BEAT_W-1:0] BL_BEATS_4 = 4'h4;
  localparam logic [BEAT_W-1:0] BL_BEATS_8 = 4'h8;
  localparam logic [BA_W-1:0] SEL_MR = 3'h0;
  localparam logic [BA_W-1:0] SEL_EMR1 = 3'h1;

  // reset values
  localparam logic [ADDR_W-1:0] MR_RST = 14'h0002;
  localparam logic [ADDR_W-1:0] EMR1_RST = 14'h0000;

  // burst state, gray along idle->write and idle->read
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WR = 2'b01,
    ST_RD = 2'b10
  } d2pi_state_t;
endpackage

// ===== sim/d2pi_chk.sv
// Purpose: port assertions for the pin interface core
// Assumes: pins steady across each link clock half period
// Notes: bound to the core below
`timescale 1ns/1ps
`default_nettype none
module d2pi_chk (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic odt,
  input wire logic org_x8,
  input wire logic [15:0] dq_out,
  input wire logic [1:0] dq_oe,
  input wire logic [1:0] dqs_out,
  input wire logic [1:0] dqs_oe,
  input wire logic [1:0] dqs_n_oe,
  input wire logic odt_term,
  input wire logic [13:0] mode_reg,
  input wire logic [13:0] ext_mode_reg1
);
  import d2pi_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  // termination needs the request and the register enable
  property p_odt_gate;
    $rose(odt_term) |-> $past(ext_mode_reg1[2] | ext_mode_reg1[6]);
  endproperty
  a_odt_gate: assert property (p_odt_gate) else $error("odt gate");
  property p_odt_src;
    $rose(odt_term) |-> $past(odt, 3) || $past(odt, 4);
  endproperty
  a_odt_src: assert property (p_odt_src) else $error("odt source");
  // deselected commands leave the mode registers alone
  property p_cs_ignore;
    cs_n [*8] |=> $stable(mode_reg) && $stable(ext_mode_reg1);
  endproperty
  a_cs_ignore: assert property (p_cs_ignore) else $error("deselect");
  // register writes only after a rising crossing
  property p_ck_sample;
    $changed(mode_reg) || $changed(ext_mode_reg1) |-> $past(ck, 3);
  endproperty
  a_ck_sample: assert property (p_ck_sample) else $error("ck sample");
  property p_dqsn_ctl;
    $stable(ext_mode_reg1[10]) |-> dqs_n_oe == (ext_mode_reg1[10] ? 2'h0 : dqs_oe);
  endproperty
  a_dqsn_ctl: assert property (p_dqsn_ctl) else $error("dqs_n enable");
  property p_lanes;
    dq_oe != 2'h0 |-> dqs_oe[0] && dq_oe == (org_x8 ? 2'h1 : 2'h3);
  endproperty
  a_lanes: assert property (p_lanes) else $error("lanes");
  property p_rdqs;
    org_x8 && dq_oe[0] |-> dqs_oe[1] == ext_mode_reg1[11];
  endproperty
  a_rdqs: assert property (p_rdqs) else $error("rdqs");
  // read data moves only with the strobe
  property p_edge_align;
    dq_oe[0] && $past(dq_oe[0]) && $changed(dq_out[7:0]) |-> $changed(dqs_out[0]);
  endproperty
  a_edge_align: assert property (p_edge_align) else $error("edge align");
  cover property (dq_oe == 2'h3);
  cover property (org_x8 && dqs_oe == 2'h3);
  cover property ($rose(odt_term));
endmodule // d2pi_chk
bind d2pi_core d2pi_chk d2pi_chk_inst (.sys_clk(sys_clk), .arst_n(arst_n), .ck(ck),
  .cs_n(cs_n), .odt(odt), .org_x8(org_x8), .dq_out(dq_out), .dq_oe(dq_oe),
  .dqs_out(dqs_out), .dqs_oe(dqs_oe), .dqs_n_oe(dqs_n_oe), .odt_term(odt_term),
  .mode_reg(mode_reg), .ext_mode_reg1(ext_mode_reg1));
`default_nettype wire

// ===== sim/d2pi_ctl.sv
// Purpose: controller-side model driving clock, command, strobe and data pins
// Assumes: tasks are entered at a falling sys_clk edge
// Notes: link clock rests low between frames
`timescale 1ns/1ps
`default_nettype none
module d2pi_ctl (
  input wire logic sys_clk,
  output var logic ck,
  output var logic ck_n,
  output var logic [3:0] cmd,
  output var logic [2:0] ba,
  output var logic [13:0] addr,
  output var logic [1:0] dm,
  output var logic [15:0] dq,
  output var logic [1:0] dqs
);
  import d2pi_pkg::*;
  // idle levels
  initial {ck, ck_n, cmd, ba, addr, dm, dq, dqs} = {2'h1, CMD_NOP, 37'h0};
  // half a link clock period
  task automatic half();
    repeat (4) @(negedge sys_clk);
  endtask
  // one crossing of the differential clock
  task automatic toggle();
    ck = ~ck;
    ck_n = ~ck_n;
  endtask
  // code lines held across a whole link clock
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    {cmd, ba, addr} = {c, b, a}; // bank, row, column or opcode
    half();
    toggle();
    half();
    toggle();
    {cmd, ba, addr} = {CMD_NOP, ~b, ~a}; // released lines lose the old value
    // let an edge pass so a following call never re-drives in the same step
    @(negedge sys_clk);
  endtask
  // strobe edge centred in each write beat
  task automatic wr_burst(input int n, input logic [15:0] d [8], input logic [1:0] m [8]);
    for (int k = 0; k < n; k++) begin
      {dq, dm} = {d[k], m[k]};
      half();
      dqs = ~dqs;
      half();
    end
    dq = ~dq;
  endtask
endmodule // d2pi_ctl
`default_nettype wire

// ===== sim/tb.sv
// Purpose: self-checking bench for the pin interface core
// Assumes: inputs change at falling sys_clk edges
// Notes: memory and burst order come from the bench model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import d2pi_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic odt = 1'b0;
  logic org_x8 = 1'b0;
  logic ck, ck_n, odt_term;
  logic [3:0] cmd;
  logic [2:0] ba;
  logic [13:0] addr, mode_reg, ext_mode_reg1;
  logic [1:0] dm, dqsc, dqs_pin, dq_oe, dqs_out, dqs_n_out, dqs_oe, dqs_n_oe;
  logic [15:0] dqc, dq_pin, dq_out;
  logic [7:0] bank_open;
  logic [31:0] seed = 32'hF304;
  logic [15:0] mem [256];
  int checks = 0;
  int fail_count = 0;
  initial forever #25 sys_clk = ~sys_clk;
  // shared pins resolved from both drivers
  assign dq_pin = {dq_oe[1] ? dq_out[15:8] : dqc[15:8], dq_oe[0] ? dq_out[7:0] : dqc[7:0]};
  assign dqs_pin = (dqs_oe & dqs_out) | (~dqs_oe & dqsc);
  d2pi_ctl d2pi_ctl_inst (.sys_clk(sys_clk), .ck(ck), .ck_n(ck_n), .cmd(cmd), .ba(ba),
    .addr(addr), .dm(dm), .dq(dqc), .dqs(dqsc));
  d2pi_core d2pi_core_inst (.sys_clk(sys_clk), .arst_n(arst_n), .ck(ck), .ck_n(ck_n),
    .cke(1'b1), .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]), .we_n(cmd[0]), .ba(ba),
    .addr(addr), .odt(odt), .dm_l(dm[0]), .dm_u(dm[1]), .org_x8(org_x8), .dq_in(dq_pin),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_pin), .dqs_out(dqs_out),
    .dqs_n_out(dqs_n_out), .dqs_oe(dqs_oe), .dqs_n_oe(dqs_n_oe), .odt_term(odt_term),
    .bank_open(bank_open), .mode_reg(mode_reg), .ext_mode_reg1(ext_mode_reg1));
  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // slot of beat k: wraps inside the burst-sized block
  function automatic int idx(int b, int col, int k, int bl, logic il);
    return b * 32 + (col & (32 - bl)) + (il ? ((col ^ k) % bl) : ((col + k) % bl));
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one mode: program, open a bank, write plain then masked, read back
  task automatic burst(input logic [13:0] mr, input logic [13:0] emr, input logic x8);
    logic [15:0] d [8];
    logic [1:0] m [8];
    logic [1:0] so;
    logic [5:0] st;
    logic [15:0] lm;
    int bl, b, col, i, p, j;
    bl = mr[0] ? 8 : 4;
    b = int'(rnd() & 32'h7);
    col = int'(rnd() & 32'h3FF);
    so = (x8 && !emr[11]) ? 2'h1 : 2'h3;
    st = {x8 ? 2'h1 : 2'h3, so, emr[10] ? 2'h0 : so};
    org_x8 = x8;
    d2pi_ctl_inst.issue(CMD_PRE, 3'h0, 14'h0400);
    d2pi_ctl_inst.issue(CMD_MRS, SEL_MR, mr);
    d2pi_ctl_inst.issue(CMD_MRS, SEL_EMR1, emr);
    chk({2'h0, ext_mode_reg1}, {2'h0, emr});
    d2pi_ctl_inst.issue(CMD_ACT, 3'(b), 14'(rnd()));
    for (p = 0; p < 2; p++) begin
      for (i = 0; i < bl; i++) begin
        d[i] = 16'(rnd());
        m[i] = p ? 2'(rnd()) : 2'h0;
        j = idx(b, col, i, bl, mr[3]);
        // eight-bit parts with the redundant strobe on ignore the mask
        if (!m[i][0] || (x8 && emr[EMR1_RDQS_BIT])) mem[j][7:0] = d[i][7:0];
        if (!m[i][1] && !x8) mem[j][15:8] = d[i][15:8];
      end
      d2pi_ctl_inst.issue(CMD_WR, 3'(b), 14'(col));
      d2pi_ctl_inst.wr_burst(bl, d, m);
    end
    // read with auto-precharge; the falling crossing inside the command
    // launches beat 0, so each sample, taken just before the next beat
    // lands, still shows beat i
    lm = x8 ? 16'h00FF : 16'hFFFF;
    d2pi_ctl_inst.issue(CMD_RD, 3'(b), 14'(col) | 14'h0400);
    d2pi_ctl_inst.half();
    for (i = 0; i < bl; i++) begin
      d2pi_ctl_inst.toggle();
      repeat (3) @(negedge sys_clk);
      j = idx(b, col, i, bl, mr[3]);
      chk(dq_out & lm, mem[j] & lm);
      chk({8'h0, dq_oe, dqs_oe, dqs_n_oe, dqs_out[0], dqs_n_out[0]},
          {8'h0, st, !i[0], i[0]});
      @(negedge sys_clk);
    end
    repeat (2) @(negedge sys_clk);
    chk({12'h0, dq_oe, dqs_oe}, 16'h0);
    chk({8'h0, bank_open}, 16'h0);
    $display("test burst mode %h done", mr);
  endtask
  // watchdog well past the expected 1100 or so cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (10) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk({2'h0, mode_reg}, {2'h0, MR_RST});
    chk({7'h0, bank_open, odt_term}, 16'h0);
    odt = 1'b1;
    d2pi_ctl_inst.issue(CMD_NOP, 3'h0, 14'h0);
    chk({15'h0, odt_term}, 16'h0);
    d2pi_ctl_inst.issue(CMD_MRS, SEL_EMR1, 14'h0004);
    d2pi_ctl_inst.issue(CMD_NOP, 3'h0, 14'h0);
    chk({15'h0, odt_term}, 16'h1);
    odt = 1'b0;
    d2pi_ctl_inst.issue(4'h8, SEL_MR, 14'h0003);
    chk({15'h0, odt_term}, 16'h0);
    chk({2'h0, mode_reg}, {2'h0, MR_RST});
    $display("test odt and deselect done");
    for (int b = 0; b < 8; b++)
      d2pi_ctl_inst.issue(CMD_ACT, 3'(b), 14'(rnd()));
    chk({8'h0, bank_open}, 16'h00FF);
    d2pi_ctl_inst.issue(CMD_PRE, 3'h3, 14'h0000);
    chk({8'h0, bank_open}, 16'h00F7);
    d2pi_ctl_inst.issue(CMD_PRE, 3'h3, 14'h0400);
    chk({8'h0, bank_open}, 16'h0000);
    $display("test banks done");
    burst(14'h0002, 14'h0004, 1'b0);
    burst(14'h0003, 14'h0000, 1'b0);
    burst(14'h000B, 14'h0400, 1'b0);
    burst(14'h000A, 14'h0044, 1'b0);
    burst(14'h0003, 14'h0C04, 1'b1);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
